// *** include/pctmr_pkg.sv ***
/*
 Package for the prescaled countdown timer with interrupt mask and status.
 Assumes a single 50 MHz system clock and an APB register bus.
*/
package pctmr_pkg;
   localparam int unsigned   CLK_MHZ          = 50;
   localparam logic [11:0]   OFS_IRQ_MASK     = 12'h000;
   localparam logic [11:0]   OFS_IRQ_PEND     = 12'h004;
   localparam logic [11:0]   OFS_TMR_CTRL     = 12'h008;
   localparam logic [11:0]   OFS_TMR_PERIOD   = 12'h00C;
   localparam logic [11:0]   OFS_TMR_COUNT    = 12'h010;
   localparam logic [11:0]   OFS_IRQ_RAISE    = 12'h014;

   localparam int unsigned   BIT_DIS          = 6;
   localparam int unsigned   BIT_RELOAD       = 5;
   localparam int unsigned   BIT_RUN          = 4;
   localparam int unsigned   IRQ_EXT0         = 4;
   localparam int unsigned   IRQ_EXT1         = 5;
   localparam int unsigned   IRQ_TIMER        = 8;
   localparam int unsigned   IRQ_DEBUG        = 15;

   localparam logic [15:0]   W1C_MASK         = 16'h0130;
   localparam logic [15:0]   SRC_VALID        = 16'h873F;
   localparam logic [15:0]   CTRL_VALID       = 16'h007F;
   localparam logic [15:0]   RST_MASK         = 16'h0000;
   localparam logic [15:0]   RST_PEND         = 16'h0000;
   localparam logic [15:0]   RST_CTRL         = 16'h0040;
   localparam logic [15:0]   RST_PERIOD       = 16'hFFFF;
   localparam logic [15:0]   RST_COUNT        = 16'h0000;
   localparam logic [15:0]   PRESC_MAX        = 16'hFFFF;
endpackage

// *** include/pctmr_tick_if.sv ***
/*
 Carrier between the timer core and its prescaler.
 Assumes both ends run on the system clock.
*/
`timescale 1ns/1ns
interface pctmr_tick_if;
   logic       run;
   logic [3:0] sel;
   logic       tick;
   modport core (output run, output sel, input tick);
   modport presc (input run, input sel, output tick);
endinterface

// *** rtl/pctmr_presc.sv ***
/*
 Prescaler: one-cycle tick every 2**(sel+1) system clocks while run is high.
 Assumes the system clock stands in for the core clock output.
*/
`timescale 1ns/1ns
module pctmr_presc
(
   input  wire logic      clk_sys_i,
   input  wire logic      reset_i,
   pctmr_tick_if.presc    tk
);
   import pctmr_pkg::*;

   logic [15:0] cnt_ff;
   logic [15:0] lim;

   assign lim = 16'((32'h2 << tk.sel) - 32'h1);

   // Halted prescaler keeps its phase: disable stops it but never resets it
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         cnt_ff <= 16'h0000;
      else if (tk.run)
         cnt_ff <= (cnt_ff >= lim) ? 16'h0000 : cnt_ff + 16'h0001;
   end

   assign tk.tick = tk.run && (cnt_ff >= lim);
endmodule

// *** rtl/pctmr_top.sv ***
/*
 Prescaled countdown timer with interrupt mask and pending-status registers.
 Assumes an APB master on the system clock; interrupt sources arrive as pulses.
*/
// Chosen here: the APB register port and the address map.
// Overview of operation
// - Disable bit stops prescaler and timer; period and count are kept.
// - Reload clear: timer halts at zero and stays halted.
// - Reload set: count reloads from period at zero, repeating forever.
// - Run bit clear freezes the count at its present value.
// - Run bit set decrements the count once per prescaled tick.
// - Four-bit divider select gives tick at clock over 2**(code+1).
// - Mask bit zero blocks a source, one lets it through; timer is bit 8.
// - Status bit one means interrupt recognised and pending or in service.
// - Writing one to status bits 4, 5, 8 clears them; zero keeps them.
// - Debug-port interrupt sits at bit 15 and may bypass the mask.
`timescale 1ns/1ns
module pctmr_top
(
   input  wire logic        clk_sys_i,
   input  wire logic        reset_i,
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [11:0] paddr_i,
   input  wire logic [31:0] pwdata_i,
   output logic      [31:0] prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   input  wire logic [15:0] irq_src_i,
   input  wire logic        debug_unmaskable_i,
   output logic             irq_o,
   output logic             tick_o
);
   import pctmr_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_HALT} pctmr_state_e;

   logic [15:0]  mask_ff;
   logic [15:0]  pend_ff;
   logic [15:0]  ctrl_ff;
   logic [15:0]  period_ff;
   logic [15:0]  count_ff;
   logic [31:0]  rdata_ff;
   logic         irq_ff;
   pctmr_state_e state_ff;
   logic         wr_en;
   logic         rd_en;
   logic         hit;
   logic         tmr_tick;
   logic         zero_evt;
   logic [15:0]  set_vec;
   logic [15:0]  clr_vec;
   logic [15:0]  nxt_pend;
   logic [15:0]  sw_raise;
   logic [15:0]  eff_mask;
   pctmr_tick_if tk ();

   assign wr_en = psel_i && penable_i && pwrite_i;
   assign rd_en = psel_i && penable_i && !pwrite_i;
   always_comb
   begin
      unique case (paddr_i)
         OFS_IRQ_MASK, OFS_IRQ_PEND, OFS_TMR_CTRL,
         OFS_TMR_PERIOD, OFS_TMR_COUNT, OFS_IRQ_RAISE: hit = 1'b1;
         default:                                       hit = 1'b0;
      endcase
   end
   assign pready_o  = 1'b1;
   assign pslverr_o = psel_i && penable_i && !hit;
   assign prdata_o  = rdata_ff;

   // Prescaler runs only when enabled and counting
   assign tk.run = !ctrl_ff[BIT_DIS] && ctrl_ff[BIT_RUN] && (state_ff == ST_RUN);
   assign tk.sel = ctrl_ff[3:0];
   assign tmr_tick = tk.tick;
   assign tick_o   = tmr_tick;

   pctmr_presc u_presc
   (
      .clk_sys_i (clk_sys_i),
      .reset_i   (reset_i),
      .tk        (tk)
   );

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         mask_ff <= RST_MASK;
      else if (wr_en && paddr_i == OFS_IRQ_MASK)
         mask_ff <= pwdata_i[15:0] & SRC_VALID;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         ctrl_ff <= RST_CTRL;
      else if (wr_en && paddr_i == OFS_TMR_CTRL)
         ctrl_ff <= pwdata_i[15:0] & CTRL_VALID;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         period_ff <= RST_PERIOD;
      else if (wr_en && paddr_i == OFS_TMR_PERIOD)
         period_ff <= pwdata_i[15:0];
   end

   // Count: period writes load period and count together, a fresh start
   assign zero_evt = tmr_tick && (count_ff == 16'h0001 || count_ff == 16'h0000);
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         count_ff <= RST_COUNT;
      else if (wr_en && paddr_i == OFS_TMR_PERIOD)
         count_ff <= pwdata_i[15:0];
      else if (zero_evt && ctrl_ff[BIT_RELOAD])
         count_ff <= period_ff;
      else if (zero_evt)
         count_ff <= 16'h0000;
      else if (tmr_tick)
         count_ff <= count_ff - 16'h0001;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         state_ff <= ST_IDLE;
      else if (wr_en && paddr_i == OFS_TMR_PERIOD)
         state_ff <= ST_RUN;
      else
      begin
         unique case (state_ff)
            ST_IDLE: state_ff <= ST_IDLE;
            ST_RUN:  if (zero_evt && !ctrl_ff[BIT_RELOAD]) state_ff <= ST_HALT;
            ST_HALT: state_ff <= ST_HALT;
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // Software raise register lets tests exercise sources not wired here
   assign sw_raise = (wr_en && paddr_i == OFS_IRQ_RAISE) ? pwdata_i[15:0] : 16'h0000;
   always_comb
   begin
      set_vec = (irq_src_i | sw_raise) & SRC_VALID;
      set_vec[IRQ_TIMER] = zero_evt;
      clr_vec = (wr_en && paddr_i == OFS_IRQ_PEND) ? (pwdata_i[15:0] & W1C_MASK) : 16'h0000;
      // Set beats clear so a same-cycle event survives
      nxt_pend = (pend_ff & ~clr_vec) | set_vec;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         pend_ff <= RST_PEND;
      else
         pend_ff <= nxt_pend;
   end

   always_comb
   begin
      eff_mask = mask_ff;
      eff_mask[IRQ_DEBUG] = mask_ff[IRQ_DEBUG] | debug_unmaskable_i;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         irq_ff <= 1'b0;
      else
         irq_ff <= |(pend_ff & eff_mask);
   end
   assign irq_o = irq_ff;

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         rdata_ff <= 32'h0000_0000;
      else if (psel_i && !penable_i && !pwrite_i)
      begin
         unique case (paddr_i)
            OFS_IRQ_MASK:   rdata_ff <= {16'h0000, mask_ff};
            OFS_IRQ_PEND:   rdata_ff <= {16'h0000, pend_ff};
            OFS_TMR_CTRL:   rdata_ff <= {16'h0000, ctrl_ff};
            OFS_TMR_PERIOD: rdata_ff <= {16'h0000, period_ff};
            OFS_TMR_COUNT:  rdata_ff <= {16'h0000, count_ff};
            default:        rdata_ff <= 32'h0000_0000;
         endcase
      end
   end

   a_dis_freezes: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ctrl_ff[BIT_DIS] && !(wr_en && paddr_i == OFS_TMR_PERIOD)
      |=> $stable(count_ff))
      else $error("count moved while disabled");

   a_halt_sticks: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      state_ff == ST_HALT && !(wr_en && paddr_i == OFS_TMR_PERIOD)
      |=> state_ff == ST_HALT)
      else $error("halted timer restarted");

   a_reload_period: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      zero_evt && ctrl_ff[BIT_RELOAD] && !wr_en
      |=> count_ff == $past(period_ff))
      else $error("reload missed");

   a_run_freeze: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !ctrl_ff[BIT_RUN] && !wr_en
      |=> $stable(count_ff))
      else $error("count moved while run clear");

   a_tick_decrement: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      tmr_tick && !zero_evt && !wr_en
      |=> count_ff == $past(count_ff) - 16'h0001)
      else $error("decrement wrong");

   a_div2_spacing: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      tmr_tick && tk.sel == 4'h0 && tk.run ##1 tk.run && tk.sel == 4'h0
      |-> !tmr_tick)
      else $error("div-by-2 ticks too close");

   a_w1c_clears: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_IRQ_PEND && pwdata_i[IRQ_EXT0] && !irq_src_i[IRQ_EXT0]
      |=> !pend_ff[IRQ_EXT0])
      else $error("w1c failed");

   a_timer_pend: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      zero_evt
      |=> pend_ff[IRQ_TIMER] ##1 (irq_o || !$past(mask_ff[IRQ_TIMER])))
      else $error("timer pending wrong");

   a_mask_blocks: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (pend_ff & eff_mask) == 16'h0000
      |=> !irq_o)
      else $error("masked irq leaked");

   a_debug_bypass: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      pend_ff[IRQ_DEBUG] && debug_unmaskable_i
      |=> irq_o)
      else $error("debug irq blocked");

   a_pend_hold: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      pend_ff[IRQ_EXT1] && !wr_en
      |=> pend_ff[IRQ_EXT1])
      else $error("pending bit lost");

   // Tick spacing measured apart from the prescaler, trusted only after an unbroken run
   logic [16:0] gap_ff;
   logic [3:0]  gap_sel_ff;
   logic        gap_ok_ff;
   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         gap_ff <= 17'h00000;
      else if (tmr_tick)
         gap_ff <= 17'h00001;
      else if (tk.run && gap_ff != 17'h1FFFF)
         gap_ff <= gap_ff + 17'h00001;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         gap_ok_ff <= 1'b0;
      else if (tmr_tick)
         gap_ok_ff <= 1'b1;
      else if (!tk.run || tk.sel != gap_sel_ff)
         gap_ok_ff <= 1'b0;
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (reset_i)
         gap_sel_ff <= 4'h0;
      else if (tmr_tick)
         gap_sel_ff <= tk.sel;
   end

   a_tick_spacing: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      tmr_tick && gap_ok_ff && tk.sel == gap_sel_ff
      |-> gap_ff == (17'h00002 << tk.sel))
      else $error("prescaled tick spacing wrong");

   a_dis_no_tick: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      ctrl_ff[BIT_DIS]
      |-> !tmr_tick)
      else $error("tick while disabled");

   a_halt_entry: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      zero_evt && !ctrl_ff[BIT_RELOAD] && !(wr_en && paddr_i == OFS_TMR_PERIOD)
      |=> state_ff == ST_HALT && count_ff == 16'h0000)
      else $error("one-shot did not stop at zero");

   a_period_arms: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_TMR_PERIOD
      |=> period_ff == $past(pwdata_i[15:0]) && count_ff == period_ff && state_ff == ST_RUN)
      else $error("period write did not arm timer");

   a_mask_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_IRQ_MASK
      |=> mask_ff == ($past(pwdata_i[15:0]) & SRC_VALID))
      else $error("mask write lost");

   a_irq_raise: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      (pend_ff & eff_mask) != 16'h0000
      |=> irq_o)
      else $error("unmasked irq not signalled");

   a_ctrl_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_TMR_CTRL
      |=> ctrl_ff == ($past(pwdata_i[15:0]) & CTRL_VALID))
      else $error("control write lost");

   a_src_sets: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      irq_src_i[IRQ_EXT0]
      |=> pend_ff[IRQ_EXT0])
      else $error("source event not recorded");

   a_w1c_timer: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_IRQ_PEND && pwdata_i[IRQ_TIMER] && !zero_evt
      |=> !pend_ff[IRQ_TIMER])
      else $error("timer pending not cleared");

   a_w1c_spares: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && paddr_i == OFS_IRQ_PEND && pend_ff[0]
      |=> pend_ff[0])
      else $error("non-clearable bit cleared");

   a_timer_src_only: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      !zero_evt && !pend_ff[IRQ_TIMER]
      |=> !pend_ff[IRQ_TIMER])
      else $error("timer pending without zero");

   a_bad_addr_nop: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      wr_en && !hit
      |=> $stable(mask_ff) && $stable(ctrl_ff) && $stable(period_ff))
      else $error("unmapped write changed a register");

   a_count_read: assert property (@(posedge clk_sys_i) disable iff (reset_i)
      psel_i && !penable_i && !pwrite_i && paddr_i == OFS_TMR_COUNT
      |=> prdata_o == {16'h0000, $past(count_ff)})
      else $error("count read data wrong");
endmodule

// *** test/pctmr_top_bench.sv ***
/*
 Directed bench for the prescaled countdown timer and its interrupt registers.
 Assumes APB answers gated by pready and a single 50 MHz system clock.
*/
`timescale 1ns/1ns
module pctmr_top_bench;
   import pctmr_pkg::*;
   logic        clk_sys_i = 1'b0;
   logic        reset_i = 1'b1;
   logic        psel_i = 1'b0;
   logic        penable_i = 1'b0;
   logic        pwrite_i = 1'b0;
   logic [11:0] paddr_i = 12'h000;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic        pready_o;
   logic        pslverr_o;
   logic [15:0] irq_src_i = 16'h0000;
   logic        debug_unmaskable_i = 1'b0;
   logic        irq_o;
   logic        tick_o;
   int          err_total = 0;
   int          checked = 0;
   int          cycles = 0;
   logic [31:0] rd;
   logic [31:0] rd2;
   logic        er;
   int          ticks;

   pctmr_top uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
      .irq_src_i(irq_src_i), .debug_unmaskable_i(debug_unmaskable_i), .irq_o(irq_o),
      .tick_o(tick_o));

   initial
   begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   task report_and_stop;
      $display("Comparisons %0d, mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Run is far shorter than this; reaching it means a hang
   always @(posedge clk_sys_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         err_total++;
         report_and_stop();
      end
   end

   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task cyc(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   // Request held until pready is sampled high, then released
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_sys_i);
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clk_sys_i);
      penable_i <= 1'b1;
      @(posedge clk_sys_i);
      // Only the bench timeout ends a wait for pready
      while (pready_o !== 1'b1)
         @(posedge clk_sys_i);
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
   endtask

   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task rdc(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask

   task pulse(input logic [15:0] v);
      @(posedge clk_sys_i);
      irq_src_i <= v;
      @(posedge clk_sys_i);
      irq_src_i <= 16'h0000;
   endtask

   // Cycles between two prescaled ticks
   task tick_gap(input int exp);
      int n;
      n = 0;
      while (tick_o !== 1'b1 && n < 5000)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      @(posedge clk_sys_i);
      n = 1;
      while (tick_o !== 1'b1 && n < 5000)
      begin
         @(posedge clk_sys_i);
         n++;
      end
      chk(n, exp);
   endtask

   // Count must not move, and ticks are tallied
   task hold_chk;
      apb(1'b0, OFS_TMR_COUNT, 32'h0);
      rd2 = rd;
      ticks = 0;
      repeat (300)
      begin
         @(posedge clk_sys_i);
         if (tick_o === 1'b1)
            ticks++;
      end
      apb(1'b0, OFS_TMR_COUNT, 32'h0);
   endtask

   initial
   begin
      cyc(4);
      reset_i <= 1'b0;
      rdc(OFS_TMR_CTRL, {16'h0000, RST_CTRL});
      rdc(OFS_IRQ_PEND, 32'h0);
      rdc(OFS_TMR_COUNT, 32'h0);
      apb(1'b0, 12'h018, 32'h1234_5678);
      chk(rd, 32'h0);
      chk(er, 1'b1);
      wr(OFS_IRQ_MASK, 32'h0000_FFFF);
      rdc(OFS_IRQ_MASK, {16'h0000, SRC_VALID});
      wr(OFS_IRQ_MASK, 32'h0000_0010);
      pulse(16'h0031);
      rdc(OFS_IRQ_PEND, 32'h0000_0031);
      cyc(2);
      chk(irq_o, 1'b1);
      wr(OFS_IRQ_MASK, 32'h0);
      cyc(2);
      chk(irq_o, 1'b0);
      wr(OFS_IRQ_PEND, 32'h0000_0031);
      rdc(OFS_IRQ_PEND, 32'h0000_0001);
      wr(OFS_IRQ_MASK, 32'h0000_0010);
      cyc(2);
      chk(irq_o, 1'b0);
      wr(OFS_IRQ_MASK, 32'h0);
      pulse(16'h8000);
      @(posedge clk_sys_i);
      debug_unmaskable_i <= 1'b1;
      cyc(3);
      chk(irq_o, 1'b1);
      debug_unmaskable_i <= 1'b0;
      cyc(3);
      chk(irq_o, 1'b0);
      rdc(OFS_IRQ_PEND, 32'h0000_8001);
      for (int s = 0; s < 4; s++)
      begin
         wr(OFS_TMR_CTRL, 32'h0000_0030 | (2 * s));
         wr(OFS_TMR_PERIOD, 32'h0000_FFFF);
         tick_gap(2 << (2 * s));
      end
      wr(OFS_TMR_CTRL, 32'h0000_0026);
      hold_chk();
      chk(rd, rd2);
      wr(OFS_TMR_CTRL, 32'h0000_0076);
      hold_chk();
      chk(rd, rd2);
      chk(ticks, 0);
      wr(OFS_TMR_CTRL, 32'h0000_0036);
      cyc(300);
      apb(1'b0, OFS_TMR_COUNT, 32'h0);
      chk(rd < rd2, 1'b1);
      wr(OFS_TMR_CTRL, 32'h0000_0010);
      wr(OFS_IRQ_PEND, 32'h0000_0100);
      wr(OFS_TMR_PERIOD, 32'h0000_0003);
      cyc(30);
      rdc(OFS_IRQ_PEND, 32'h0000_8101);
      rdc(OFS_TMR_COUNT, 32'h0);
      wr(OFS_IRQ_MASK, 32'h0000_0100);
      cyc(2);
      chk(irq_o, 1'b1);
      wr(OFS_IRQ_PEND, 32'h0000_0100);
      cyc(30);
      rdc(OFS_IRQ_PEND, 32'h0000_8001);
      wr(OFS_TMR_CTRL, 32'h0000_0030);
      wr(OFS_TMR_PERIOD, 32'h0000_0002);
      repeat (2)
      begin
         wr(OFS_IRQ_PEND, 32'h0000_0100);
         cyc(30);
         rdc(OFS_IRQ_PEND, 32'h0000_8101);
      end
      report_and_stop();
   end
endmodule
